// file: clock_switch_pkg.sv
package clock_switch_pkg;

    // Core clock rate and the settle window after a changeover
    localparam int CORE_CLK_HZ = 25_000_000;
    localparam int SETTLE_TIME_US = 150;
    localparam int SETTLE_CYCLES =
        int'((64'(SETTLE_TIME_US) * 64'(CORE_CLK_HZ) + 64'd999999) / 64'd1000000);
    localparam int SETTLE_W = 12;
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

    // Pin synchroniser depth
    localparam int SYNC_STAGES = 3;

    // Frame sync generation in bit clock periods
    localparam int FRAME_W = 9;
    localparam int FRAME_LEN_DEFAULT = 64;
    localparam int FRAME_HIGH_DEFAULT = 32;

    typedef enum logic [2:0] {
        SRC_OSC = 3'b001,
        SRC_BITCLK = 3'b010,
        SRC_PLL = 3'b100
    } core_src_t;

    typedef enum logic [2:0] {
        SW_IDLE = 3'b001,
        SW_ARMED = 3'b010,
        SW_SETTLE = 3'b100
    } switch_state_t;

    // Reset values
    localparam core_src_t SRC_RESET = SRC_OSC;
    localparam switch_state_t SW_RESET = SW_IDLE;
    localparam logic PRESENT_RESET = 1'b0;
    localparam logic PIN_HIGH_RESET = 1'b1;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] scl;
        logic [SYNC_STAGES-1:0] sda;
        logic [SYNC_STAGES-1:0] bclk;
        logic [SYNC_STAGES-1:0] present;
        logic scl_f;
        logic sda_f;
        logic sda_f_d;
        logic bclk_f;
        logic bclk_f_d;
        logic present_f;
    } pin_sync_t;

    typedef struct packed {
        pin_sync_t pins;
        switch_state_t state;
        logic applied_present;
        logic target_present;
        logic [SETTLE_W-1:0] wait_cnt;
        core_src_t src;
        logic pll_en;
    } switch_regs_t;

    typedef struct packed {
        logic [FRAME_W-1:0] cnt;
        logic fs;
    } frame_regs_t;

endpackage : clock_switch_pkg

// file: frame_sync_gen.sv
`timescale 1ns/100ps

module frame_sync_gen
    import clock_switch_pkg::*;
#(
    parameter int FRAME_LEN = FRAME_LEN_DEFAULT,
    parameter int FRAME_HIGH = FRAME_HIGH_DEFAULT
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Bit clock edge and mode
    input wire logic i_bclk_rise,
    input wire logic i_enable,
    // Frame clock
    output logic o_frame_sync
);

    localparam logic [FRAME_W-1:0] LAST = FRAME_W'(FRAME_LEN - 1);
    localparam logic [FRAME_W-1:0] HIGH_LAST = FRAME_W'(FRAME_HIGH - 1);

    initial begin
        if (FRAME_LEN < 2 || FRAME_LEN > (1 << FRAME_W) || FRAME_HIGH < 1
            || FRAME_HIGH >= FRAME_LEN) begin
            $error("frame_sync_gen: unsupported frame length or high time");
        end
    end

    frame_regs_t r;
    frame_regs_t next_r;

    // Frame edges are counted in bit clock periods, so the frame tracks the host clock
    always_comb begin
        next_r = r;
        if (!i_enable) begin
            next_r.cnt = '0;
            next_r.fs = 1'b0;
        end else if (i_bclk_rise) begin
            if (r.cnt == LAST) begin
                next_r.cnt = '0;
                next_r.fs = 1'b1;
            end else begin
                next_r.cnt = r.cnt + 1'b1;
                if (r.cnt == HIGH_LAST) begin
                    next_r.fs = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_frame_sync = r.fs;

    property p_frame_start;
        @(posedge i_core_clk) disable iff (i_rst)
        i_enable && i_bclk_rise && r.cnt == LAST |=> r.fs && r.cnt == '0;
    endproperty
    a_frame_start: assert property (p_frame_start)
        else $error("frame sync did not start a new frame");

    property p_frame_high_end;
        @(posedge i_core_clk) disable iff (i_rst)
        i_enable && i_bclk_rise && r.cnt == HIGH_LAST |=> !r.fs;
    endproperty
    a_frame_high_end: assert property (p_frame_high_end)
        else $error("frame sync high time wrong");

endmodule : frame_sync_gen

// file: core_clock_source_switch.sv
`timescale 1ns/100ps

module core_clock_source_switch
    import clock_switch_pkg::*;
#(
    parameter int FRAME_LEN = FRAME_LEN_DEFAULT,
    parameter int FRAME_HIGH = FRAME_HIGH_DEFAULT
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Control port pins
    input wire logic i_scl,
    input wire logic i_sda,
    // Control level from the register file, on the control port domain
    input wire logic i_bit_clock_present,
    // Configuration on the core domain
    input wire logic i_rate_supported,
    input wire logic i_hybrid_master,
    // Audio port bit clock pin
    input wire logic i_audio_port_bit_clock,
    // Clock source control
    output core_src_t o_core_src,
    output logic o_pll_enable,
    output logic o_switch_busy,
    // Frame clock
    output logic o_frame_sync
);

    initial begin
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > (1 << SETTLE_W)) begin
            $error("core_clock_source_switch: settle count does not fit");
        end
    end

    switch_regs_t r;
    switch_regs_t next_r;
    logic stop;
    logic bclk_rise;

    // A change counts once the second and third stages agree
    function automatic logic filt(input logic [SYNC_STAGES-1:0] s, input logic f);
        filt = (s[1] == s[2]) ? s[2] : f;
    endfunction : filt

    // Stop: data rises while the clock is high
    assign stop = r.pins.scl_f && r.pins.sda_f && !r.pins.sda_f_d;
    assign bclk_rise = r.pins.bclk_f && !r.pins.bclk_f_d;

    always_comb begin
        next_r = r;
        // Control pins are sampled on their own, free of any audio timing
        next_r.pins.scl = {r.pins.scl[1:0], i_scl};
        next_r.pins.sda = {r.pins.sda[1:0], i_sda};
        next_r.pins.bclk = {r.pins.bclk[1:0], i_audio_port_bit_clock};
        next_r.pins.present = {r.pins.present[1:0], i_bit_clock_present};
        next_r.pins.scl_f = filt(r.pins.scl, r.pins.scl_f);
        next_r.pins.sda_f = filt(r.pins.sda, r.pins.sda_f);
        next_r.pins.sda_f_d = r.pins.sda_f;
        next_r.pins.bclk_f = filt(r.pins.bclk, r.pins.bclk_f);
        next_r.pins.bclk_f_d = r.pins.bclk_f;
        next_r.pins.present_f = filt(r.pins.present, r.pins.present_f);

        case (r.state)
            SW_IDLE: begin
                if (r.pins.present_f != r.applied_present) begin
                    next_r.state = SW_ARMED;
                end
            end
            SW_ARMED: begin
                if (stop) begin
                    next_r.state = SW_SETTLE;
                    next_r.target_present = r.pins.present_f;
                    next_r.wait_cnt = '0;
                    // PLL starts early to lock in time; a PLL still feeding the core stays on
                    next_r.pll_en = r.pll_en || (r.pins.present_f && !i_rate_supported);
                end
            end
            SW_SETTLE: begin
                // Host holds off the bus for this whole window
                if (r.wait_cnt == SETTLE_LAST) begin
                    next_r.state = SW_IDLE;
                    next_r.applied_present = r.target_present;
                    if (!r.target_present) begin
                        next_r.src = SRC_OSC;
                        next_r.pll_en = 1'b0;
                    end else if (i_rate_supported) begin
                        next_r.src = SRC_BITCLK;
                        next_r.pll_en = 1'b0;
                    end else begin
                        next_r.src = SRC_PLL;
                        next_r.pll_en = 1'b1;
                    end
                end else begin
                    // Old source stays on the core until the window closes
                    next_r.wait_cnt = r.wait_cnt + 1'b1;
                end
            end
            default: begin
                next_r.state = SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            r.pins.scl <= {SYNC_STAGES{PIN_HIGH_RESET}};
            r.pins.sda <= {SYNC_STAGES{PIN_HIGH_RESET}};
            r.pins.bclk <= '0;
            r.pins.present <= {SYNC_STAGES{PRESENT_RESET}};
            r.pins.scl_f <= PIN_HIGH_RESET;
            r.pins.sda_f <= PIN_HIGH_RESET;
            r.pins.sda_f_d <= PIN_HIGH_RESET;
            r.pins.bclk_f <= 1'b0;
            r.pins.bclk_f_d <= 1'b0;
            r.pins.present_f <= PRESENT_RESET;
            r.state <= SW_RESET;
            r.applied_present <= PRESENT_RESET;
            r.target_present <= PRESENT_RESET;
            r.wait_cnt <= '0;
            r.src <= SRC_RESET;
            r.pll_en <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign o_core_src = r.src;
    assign o_pll_enable = r.pll_en;
    assign o_switch_busy = (r.state == SW_SETTLE);

    // Edge detection at core rate; only bit clocks well below half the core rate are tracked
    frame_sync_gen #(
        .FRAME_LEN(FRAME_LEN),
        .FRAME_HIGH(FRAME_HIGH)
    ) u_frame_sync_gen (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_bclk_rise(bclk_rise),
        .i_enable(i_hybrid_master && r.src != SRC_OSC),
        .o_frame_sync(o_frame_sync)
    );

    sequence s_change_seen;
        r.state == SW_IDLE && r.pins.present_f != r.applied_present;
    endsequence

    sequence s_settle_begin;
        r.state == SW_ARMED && stop;
    endsequence

    property p_change_arms;
        @(posedge i_core_clk) disable iff (i_rst)
        s_change_seen |=> r.state == SW_ARMED;
    endproperty
    a_change_arms: assert property (p_change_arms)
        else $error("level change did not arm a changeover");

    property p_armed_waits;
        @(posedge i_core_clk) disable iff (i_rst)
        r.state == SW_ARMED && !stop |=> r.state == SW_ARMED && !o_switch_busy;
    endproperty
    a_armed_waits: assert property (p_armed_waits)
        else $error("changeover began without a stop condition");

    property p_stop_starts;
        @(posedge i_core_clk) disable iff (i_rst)
        s_settle_begin |=> o_switch_busy && r.wait_cnt == '0 ##1 o_switch_busy;
    endproperty
    a_stop_starts: assert property (p_stop_starts)
        else $error("stop condition did not start the settle window");

    property p_settle_length;
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(o_switch_busy) |-> $past(r.wait_cnt) == SETTLE_LAST;
    endproperty
    a_settle_length: assert property (p_settle_length)
        else $error("settle window has the wrong length");

    property p_src_held;
        @(posedge i_core_clk) disable iff (i_rst)
        o_switch_busy && $past(o_switch_busy)
            |-> $stable(o_core_src) && (o_core_src != SRC_PLL || o_pll_enable);
    endproperty
    a_src_held: assert property (p_src_held)
        else $error("core source changed inside the settle window");

    property p_pll_unsupported;
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(o_switch_busy) && $past(r.target_present) && !$past(i_rate_supported)
            |-> o_core_src == SRC_PLL && o_pll_enable;
    endproperty
    a_pll_unsupported: assert property (p_pll_unsupported)
        else $error("unsupported rate did not select the PLL");

    property p_bypass_supported;
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(o_switch_busy) && $past(r.target_present) && $past(i_rate_supported)
            |-> o_core_src == SRC_BITCLK && !o_pll_enable;
    endproperty
    a_bypass_supported: assert property (p_bypass_supported)
        else $error("supported rate did not bypass the PLL");

    property p_osc_absent;
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(o_switch_busy) && !$past(r.target_present) |-> o_core_src == SRC_OSC;
    endproperty
    a_osc_absent: assert property (p_osc_absent)
        else $error("absent bit clock did not return to the oscillator");

endmodule : core_clock_source_switch

// file: clock_host_model.sv
`timescale 1ns/100ps

module clock_host_model #(
    parameter int BCLK_HALF = 4
) (
    input wire logic i_core_clk,
    output logic o_scl,
    output logic o_sda,
    output logic o_present,
    output logic o_bit_clock
);
    logic bclk_run;
    int half_cnt;
    int hold;

    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_present = 1'b0;
        o_bit_clock = 1'b0;
        bclk_run = 1'b0;
        half_cnt = 0;
        hold = 3;
    end

    // Bit clock stands still when stopped, so no stray edges reach the frame counter
    always @(negedge i_core_clk) begin
        if (!bclk_run) begin
            o_bit_clock <= 1'b0;
            half_cnt <= 0;
        end else if (half_cnt == BCLK_HALF - 1) begin
            o_bit_clock <= ~o_bit_clock;
            half_cnt <= 0;
        end else begin
            half_cnt <= half_cnt + 1;
        end
    end

    // Only one pin moves per step, so data changes never look like a stop
    task automatic step(input logic scl, input logic sda);
        @(negedge i_core_clk);
        o_scl = scl;
        o_sda = sda;
        repeat (hold) @(negedge i_core_clk);
    endtask : step

    task automatic send_stop();
        step(1'b1, 1'b0);
        // No hold after the stop, so the caller sees the whole settle window
        @(negedge i_core_clk);
        o_sda = 1'b1;
    endtask : send_stop

    task automatic write_level(input logic level, input logic [7:0] data, input logic stop);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, data[i]);
            step(1'b1, data[i]);
            step(1'b0, data[i]);
        end
        step(1'b0, 1'b0);
        o_present = level;
        if (stop)
            send_stop();
    endtask : write_level
endmodule : clock_host_model

// file: core_clock_source_switch_bench.sv
`timescale 1ns/100ps

module core_clock_source_switch_bench;
    import clock_switch_pkg::*;

    localparam int FLEN = 5;
    localparam int FHIGH = 2;

    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_rate_supported = 1'b1;
    logic i_hybrid_master = 1'b0;
    logic scl;
    logic sda;
    logic present;
    logic bclk;
    core_src_t o_core_src;
    logic o_pll_enable;
    logic o_switch_busy;
    logic o_frame_sync;
    int error_cnt = 0;
    int n_compared = 0;
    int r;
    logic [7:0] lfsr = 8'h42;

    always #20 i_core_clk = ~i_core_clk;

    clock_host_model host (
        .i_core_clk(i_core_clk),
        .o_scl(scl),
        .o_sda(sda),
        .o_present(present),
        .o_bit_clock(bclk)
    );

    core_clock_source_switch #(.FRAME_LEN(FLEN), .FRAME_HIGH(FHIGH)) DUT (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_scl(scl),
        .i_sda(sda),
        .i_bit_clock_present(present),
        .i_rate_supported(i_rate_supported),
        .i_hybrid_master(i_hybrid_master),
        .i_audio_port_bit_clock(bclk),
        .o_core_src(o_core_src),
        .o_pll_enable(o_pll_enable),
        .o_switch_busy(o_switch_busy),
        .o_frame_sync(o_frame_sync)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    function automatic logic [2:0] model_src(input int pres, input int rate);
        if (pres == 0)
            return SRC_OSC;
        return (rate != 0) ? SRC_BITCLK : SRC_PLL;
    endfunction : model_src

    task automatic changeover(input int level, input int rate, input int late);
        logic [2:0] old_src;
        int n;
        old_src = o_core_src;
        i_rate_supported = rate[0];
        lfsr = lfsr_next(lfsr);
        host.write_level(level[0], lfsr, late == 0);
        if (late != 0) begin
            repeat (100) @(negedge i_core_clk);
            check(o_switch_busy, 0);
            check(o_core_src, old_src);
            host.send_stop();
        end
        n = 0;
        while (o_switch_busy !== 1'b1 && n < 12) begin
            @(negedge i_core_clk);
            n++;
        end
        if (n == 12) begin
            error_cnt++;
            final_report();
        end
        n = 0;
        // The host stays off the control port for the whole window
        while (o_switch_busy === 1'b1 && n < 5000) begin
            check(o_core_src, old_src);
            check(o_pll_enable, old_src == SRC_PLL || (level != 0 && rate == 0));
            @(negedge i_core_clk);
            n++;
        end
        check(n, SETTLE_CYCLES);
        if (n == 5000)
            final_report();
        check(o_core_src, model_src(level, rate));
    endtask : changeover

    // Bit clock rises are counted between frame clock changes
    task automatic frame_run(input int cycles, output int rises);
        int edges;
        int q[$];
        logic pb;
        logic pf;
        edges = 0;
        rises = 0;
        pb = bclk;
        pf = o_frame_sync;
        repeat (cycles) begin
            @(negedge i_core_clk);
            if (bclk && !pb)
                edges++;
            if (o_frame_sync !== pf) begin
                q.push_back(edges);
                if (o_frame_sync === 1'b1)
                    rises++;
            end
            pb = bclk;
            pf = o_frame_sync;
        end
        for (int i = 1; i < q.size(); i++)
            check(q[i] - q[i-1], (i % 2 == 1) ? FHIGH : FLEN - FHIGH);
    endtask : frame_run

    initial begin
        repeat (100000) @(posedge i_core_clk);
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (20) @(negedge i_core_clk);
        i_rst = 1'b0;
        @(negedge i_core_clk);
        check(o_core_src, SRC_OSC);
        check({o_pll_enable, o_switch_busy, o_frame_sync}, 0);
        changeover(1, 1, 1);
        host.bclk_run = 1'b1;
        frame_run(200, r);
        check(r, 0);
        i_hybrid_master = 1'b1;
        frame_run(300, r);
        check(r > 3, 1);
        changeover(0, 1, 0);
        frame_run(100, r);
        check(r, 0);
        changeover(1, 0, 0);
        for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            host.hold = 3 + int'(lfsr[2:1]);
            changeover(k % 2 == 0 ? 0 : 1, int'(lfsr[0]), 0);
        end
        final_report();
    end
endmodule : core_clock_source_switch_bench
